// >>> verilog/tets_thread_svc.sv
`timescale 1ns/1ps
`include "tets_defines.svh"
module tets_thread_svc #(
  parameter int NCH       = 32,
  parameter int MEM_WORDS = 256,
  parameter int PCW       = 14
) (
  // Clock and reset.
  input  wire logic                                sys_clk,
  input  wire logic                                rst_n,
  // Host port to shared parameter memory.
  input  wire logic                                host_req,
  input  wire logic                                host_we,
  input  wire logic                                host_alias,
  input  wire logic [$clog2(MEM_WORDS)-1:0]        host_addr,
  input  wire logic [`TETS_HOST_W-1:0]             host_wdata,
  output logic      [`TETS_HOST_W-1:0]             host_rdata,
  output logic                                     host_ack,
  // Host service requests and channel priorities.
  input  wire logic                                hsr_wr,
  input  wire logic [$clog2(NCH)-1:0]              hsr_channel_select_register,
  input  wire logic [`TETS_HSR_W-1:0]              hsr_code,
  input  wire logic [NCH-1:0][`TETS_PRIO_W-1:0]    channel_select_register_prio,
  // Engine port to shared parameter memory.
  input  wire logic                                eng_req,
  input  wire logic                                eng_we,
  input  wire logic [$clog2(MEM_WORDS)-1:0]        eng_addr,
  input  wire logic [`TETS_ENG_W-1:0]              eng_wdata,
  output logic      [`TETS_ENG_W-1:0]              eng_rdata,
  output logic                                     eng_ack,
  // Engine thread control.
  input  wire logic                                thread_end,
  input  wire logic                                channel_select_register_sel_wr,
  input  wire logic [$clog2(NCH)-1:0]              channel_select_register_sel_val,
  input  wire logic                                xfer_wr,
  input  wire logic [`TETS_ENG_W-1:0]              xfer_wdata_a,
  input  wire logic [`TETS_ENG_W-1:0]              xfer_wdata_b,
  input  wire logic                                match_wr,
  input  wire logic                                svc_en_wr,
  input  wire logic                                svc_en_val,
  input  wire logic                                flag_clr,
  input  wire logic                                sub_call,
  input  wire logic [PCW-1:0]                      sub_ret_addr,
  output logic      [PCW-1:0]                      ret_addr,
  // Channel hardware.
  input  wire logic [NCH-1:0]                      channel_select_register_event,
  input  wire logic [NCH-1:0]                      link_req,
  input  wire logic [NCH-1:0][`TETS_ENG_W-1:0]     cap_a,
  input  wire logic [NCH-1:0][`TETS_ENG_W-1:0]     cap_b,
  output logic      [NCH-1:0][`TETS_ENG_W-1:0]     match_a,
  output logic      [NCH-1:0][`TETS_ENG_W-1:0]     match_b,
  // Thread status.
  output logic                                     thread_start,
  output tets_pkg::tets_entry_t                    thread_entry,
  output logic      [$clog2(NCH)-1:0]              channel_select_register_select_register,
  output logic                                     thread_running,
  output logic      [`TETS_ENG_W-1:0]              capture_transfer_regs_a,
  output logic      [`TETS_ENG_W-1:0]              capture_transfer_regs_b
);
  localparam int CW = $clog2(NCH);

  //////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  logic rst_m_ff;
  logic rst_s_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_ff <= 1'b0;
      rst_s_ff <= 1'b0;
    end else begin
      rst_m_ff <= 1'b1;
      rst_s_ff <= rst_m_ff;
    end
  end
  wire rst_sync_n = rst_s_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Shared memory. One port per cycle, so a word is never half written.
  logic [`TETS_HOST_W-1:0] mem [MEM_WORDS];
  logic                    rr_ff;
  logic                    host_ack_ff;
  logic                    eng_ack_ff;
  logic [`TETS_HOST_W-1:0] host_rdata_ff;
  logic [`TETS_ENG_W-1:0]  eng_rdata_ff;
  wire host_want = host_req && !host_ack_ff;
  wire eng_want  = eng_req && !eng_ack_ff;
  wire host_go   = host_want && (!eng_want || !rr_ff);
  wire eng_go    = eng_want && !host_go;
  wire [`TETS_HOST_W-1:0] host_word = mem[host_addr];
  wire [`TETS_HOST_W-1:0] eng_word  = mem[eng_addr];
  wire [`TETS_HOST_W-1:0] host_sext = {{`TETS_EXT_W{host_word[`TETS_ENG_W-1]}},
                                       host_word[`TETS_ENG_W-1:0]};
  wire [`TETS_HOST_W-1:0] host_alias_wr = {host_word[`TETS_HOST_W-1:`TETS_ENG_W],
                                           host_wdata[`TETS_ENG_W-1:0]};
  wire [`TETS_HOST_W-1:0] eng_wr_word = {eng_word[`TETS_HOST_W-1:`TETS_ENG_W],
                                         eng_wdata};
  wire [`TETS_HOST_W-1:0] host_wr_word = host_alias ? host_alias_wr : host_wdata;

  // Memory contents carry no reset; a RAM macro could not provide one.
  always_ff @(posedge sys_clk) begin
    if (host_go && host_we) begin
      mem[host_addr] <= host_wr_word;
    end else if (eng_go && eng_we) begin
      mem[eng_addr] <= eng_wr_word;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rr_ff         <= 1'b0;
      host_ack_ff   <= 1'b0;
      eng_ack_ff    <= 1'b0;
      host_rdata_ff <= {`TETS_HOST_W{1'b0}};
      eng_rdata_ff  <= `TETS_WORD_RST;
    end else begin
      rr_ff       <= (host_want && eng_want) ? !rr_ff : rr_ff;
      host_ack_ff <= host_go;
      eng_ack_ff  <= eng_go;
      if (host_go) begin
        host_rdata_ff <= host_alias ? host_sext : host_word;
      end
      if (eng_go) begin
        eng_rdata_ff <= eng_word[`TETS_ENG_W-1:0];
      end
    end
  end
  assign host_ack   = host_ack_ff;
  assign eng_ack    = eng_ack_ff;
  assign host_rdata = host_rdata_ff;
  assign eng_rdata  = eng_rdata_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Request flags and scheduling.
  tets_pkg::tets_state_t         state_ff;
  tets_pkg::tets_entry_t         entry_ff;
  logic [NCH-1:0][`TETS_HSR_W-1:0] hsr_ff;
  logic [NCH-1:0]                svc_en_ff;
  logic [NCH-1:0]                flag_ff;
  logic [NCH-1:0]                link_ff;
  logic                          started_ff;
  logic                          start_ff;
  logic [CW-1:0]                 cur_ff;
  logic [NCH-1:0]                elig;
  logic [CW-1:0]                 pick;
  wire run = (state_ff == tets_pkg::st_run);

  for (genvar g = 0; g < NCH; g++) begin : g_elig
    assign elig[g] = started_ff && (channel_select_register_prio[g] != `TETS_PRIO_OFF) &&
                     ((hsr_ff[g] != `TETS_HSR_NONE) || flag_ff[g] || link_ff[g]);
  end

  // Lowest channel number wins; priority levels only gate, they do not order.
  always_comb begin
    pick = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (elig[i]) begin
        pick = CW'(i);
      end
    end
  end
  wire any_elig = |elig;
  wire launch   = !run && any_elig;
  wire tets_pkg::tets_entry_t nxt_entry = tets_pkg::tets_entry_t'(
      (hsr_ff[pick] != `TETS_HSR_NONE) ? tets_pkg::entry_host :
      link_ff[pick] ? tets_pkg::entry_link : tets_pkg::entry_channel_select_register);
  wire [CW-1:0] nxt_cur = launch ? pick : ((run && channel_select_register_sel_wr) ? channel_select_register_sel_val : cur_ff);
  wire          do_end  = run && thread_end;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_ff   <= tets_pkg::st_idle;
      entry_ff   <= tets_pkg::entry_host;
      started_ff <= 1'b0;
      start_ff   <= 1'b0;
      cur_ff     <= '0;
    end else begin
      started_ff <= started_ff || hsr_wr;
      start_ff   <= launch;
      cur_ff     <= nxt_cur;
      if (launch) begin
        state_ff <= tets_pkg::st_run;
        entry_ff <= nxt_entry;
      end else if (do_end) begin
        state_ff <= tets_pkg::st_idle;
      end
    end
  end

  // Set wins over clear for every flag.
  for (genvar g = 0; g < NCH; g++) begin : g_flags
    wire hsr_set = hsr_wr && (hsr_channel_select_register == CW'(g)) && (hsr_code != `TETS_HSR_NONE);
    wire mine    = run && (cur_ff == CW'(g));
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        hsr_ff[g]    <= `TETS_HSR_NONE;
        svc_en_ff[g] <= 1'b0;
        flag_ff[g]   <= 1'b0;
        link_ff[g]   <= 1'b0;
      end else begin
        if (hsr_set) begin
          hsr_ff[g] <= hsr_code;
        end else if (mine && thread_end) begin
          hsr_ff[g] <= `TETS_HSR_NONE;
        end
        if (mine && svc_en_wr) begin
          svc_en_ff[g] <= svc_en_val;
        end
        if (channel_select_register_event[g] && svc_en_ff[g]) begin
          flag_ff[g] <= 1'b1;
        end else if (mine && flag_clr) begin
          flag_ff[g] <= 1'b0;
        end
        if (link_req[g]) begin
          link_ff[g] <= 1'b1;
        end else if (mine && flag_clr) begin
          link_ff[g] <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transfer, match and return address registers.
  logic [`TETS_ENG_W-1:0]          xfer_a_ff;
  logic [`TETS_ENG_W-1:0]          xfer_b_ff;
  logic [PCW-1:0]                  ret_ff;
  logic [NCH-1:0][`TETS_ENG_W-1:0] match_a_ff;
  logic [NCH-1:0][`TETS_ENG_W-1:0] match_b_ff;
  wire load_cap = launch || (run && channel_select_register_sel_wr);

  // A capture load overrides an engine write in the same cycle, so code must
  // write the transfer registers only after it has chosen the channel.
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      xfer_a_ff  <= `TETS_WORD_RST;
      xfer_b_ff  <= `TETS_WORD_RST;
      ret_ff     <= '0;
      match_a_ff <= '0;
      match_b_ff <= '0;
    end else begin
      if (load_cap) begin
        xfer_a_ff <= cap_a[nxt_cur];
        xfer_b_ff <= cap_b[nxt_cur];
      end else if (run && xfer_wr) begin
        xfer_a_ff <= xfer_wdata_a;
        xfer_b_ff <= xfer_wdata_b;
      end
      if (run && match_wr) begin
        match_a_ff[cur_ff] <= xfer_a_ff;
        match_b_ff[cur_ff] <= xfer_b_ff;
      end
      if (sub_call) begin
        ret_ff <= sub_ret_addr;
      end
    end
  end

  assign ret_addr                = ret_ff;
  assign match_a                 = match_a_ff;
  assign match_b                 = match_b_ff;
  assign thread_start            = start_ff;
  assign thread_entry            = entry_ff;
  assign channel_select_register_select_register    = cur_ff;
  assign thread_running          = run;
  assign capture_transfer_regs_a = xfer_a_ff;
  assign capture_transfer_regs_b = xfer_b_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_n);

  a_alias_sign_ext: assert property (
    host_go && host_alias && !host_we |=>
      host_rdata == {{`TETS_EXT_W{$past(host_word[`TETS_ENG_W-1])}},
                     $past(host_word[`TETS_ENG_W-1:0])})
    else $error("Alias read not sign extended.");
  a_alias_keep_upper: assert property (
    host_go && host_we && host_alias |=>
      mem[$past(host_addr)][`TETS_HOST_W-1:`TETS_ENG_W] ==
      $past(host_word[`TETS_HOST_W-1:`TETS_ENG_W]))
    else $error("Alias write changed upper bits.");
  a_eng_word_write: assert property (
    eng_go && eng_we |=> mem[$past(eng_addr)] ==
      {$past(eng_word[`TETS_HOST_W-1:`TETS_ENG_W]), $past(eng_wdata)})
    else $error("Engine write not whole 24-bit word.");
  a_one_grant: assert property (
    host_want && eng_want |=> (host_ack != eng_ack) ##1 (!host_req || !eng_req || host_ack || eng_ack))
    else $error("Arbitration did not serve exactly one side.");
  a_entry_load: assert property (
    launch |=> capture_transfer_regs_a == $past(cap_a[pick]) && thread_start)
    else $error("Transfer registers not loaded on entry.");
  a_match_path: assert property (
    run && match_wr |=> match_a[$past(cur_ff)] == $past(xfer_a_ff))
    else $error("Match not written from transfer register.");
  a_hsr_clear: assert property (
    do_end && !(hsr_wr && hsr_channel_select_register == cur_ff) |=> hsr_ff[$past(cur_ff)] == `TETS_HSR_NONE)
    else $error("Host request not cleared at thread end.");
  a_resched: assert property (
    do_end && (flag_ff[cur_ff] || link_ff[cur_ff]) && !flag_clr &&
    channel_select_register_prio[cur_ff] != `TETS_PRIO_OFF |=> launch ##1 run)
    else $error("Uncleared flag not rescheduled.");
  a_no_run_early: assert property (
    !started_ff |-> !run && !launch)
    else $error("Thread ran before any host request.");
  a_prio_zero: assert property (
    launch |-> channel_select_register_prio[pick] != `TETS_PRIO_OFF)
    else $error("Zero priority channel scheduled.");
  a_entry_host: assert property (
    launch && hsr_ff[pick] != `TETS_HSR_NONE |=> thread_entry == tets_pkg::entry_host)
    else $error("Wrong entry for host request.");
  a_single_ret: assert property (
    sub_call |=> ret_addr == $past(sub_ret_addr))
    else $error("Return address not replaced by call.");
endmodule : tets_thread_svc

// >>> verilog/tets_defines.svh
`ifndef TETS_DEFINES_SVH
`define TETS_DEFINES_SVH
`define TETS_ENG_W      24
`define TETS_HOST_W     32
`define TETS_EXT_W      8
`define TETS_HSR_W      3
`define TETS_PRIO_W     2
`define TETS_PRIO_OFF   2'h0
`define TETS_HSR_NONE   3'h0
`define TETS_WORD_RST   24'h00_0000
`endif

// >>> verilog/tets_pkg.sv
package tets_pkg;
  typedef enum logic {
    st_idle,
    st_run
  } tets_state_t;
  typedef enum logic [1:0] {
    entry_host,
    entry_link,
    entry_channel_select_register
  } tets_entry_t;
endpackage : tets_pkg

// >>> testbench/tets_host_model.sv
`timescale 1ns/1ps
module tets_host_model #(
  parameter int AW = 4
) (
  // Clock.
  input  wire logic          sys_clk,
  // Memory port towards the device.
  output logic               host_req,
  output logic               host_we,
  output logic               host_alias,
  output logic [AW-1:0]      host_addr,
  output logic [31:0]        host_wdata,
  input  wire logic [31:0]   host_rdata,
  input  wire logic          host_ack
);
  initial begin
    {host_req, host_we, host_alias, host_addr, host_wdata} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One access at a time; the request stands until the acknowledge is sampled.
  task automatic access(input logic we, input logic als, input logic [AW-1:0] a,
                        input logic [31:0] d, output logic [31:0] rd, output logic ok);
    @(posedge sys_clk);
    #1;
    ok = 1'h0;
    host_req = 1'h1;
    host_we = we;
    host_alias = als;
    host_addr = a;
    host_wdata = d;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge sys_clk);
      ok = (host_ack === 1'h1);
      rd = host_rdata;
    end
    #1;
    host_req = 1'h0;
    // Released address and data lines show the inverse, so a stale value never passes for a live one.
    host_addr = ~a;
    host_wdata = ~d;
  endtask : access
endmodule : tets_host_model

// >>> testbench/tets_thread_svc_test.sv
`timescale 1ns/1ps
module tets_thread_svc_test;
  localparam int NCH = 4;
  typedef struct packed {
    logic        eng;
    logic        we;
    logic        als;
    logic [3:0]  addr;
    logic [31:0] wd;
    logic [31:0] exp;
  } tets_row_t;
  // Writes carry no expectation; engine reads expect a zero upper byte.
  localparam tets_row_t ROWS [11] = '{
    '{1'h0, 1'h1, 1'h0, 4'h1, 32'h1280_0001, 32'h0},
    '{1'h0, 1'h0, 1'h0, 4'h1, 32'h0, 32'h1280_0001},
    '{1'h0, 1'h0, 1'h1, 4'h1, 32'h0, 32'hff80_0001},
    '{1'h0, 1'h1, 1'h1, 4'h1, 32'h007f_fffe, 32'h0},
    '{1'h0, 1'h0, 1'h0, 4'h1, 32'h0, 32'h127f_fffe},
    '{1'h1, 1'h1, 1'h0, 4'h1, 32'h0080_0003, 32'h0},
    '{1'h0, 1'h0, 1'h0, 4'h1, 32'h0, 32'h1280_0003},
    '{1'h1, 1'h0, 1'h0, 4'h1, 32'h0, 32'h0080_0003},
    '{1'h0, 1'h1, 1'h0, 4'hf, 32'ha500_0000, 32'h0},
    '{1'h0, 1'h0, 1'h1, 4'hf, 32'h0, 32'h0},
    '{1'h1, 1'h0, 1'h0, 4'hf, 32'h0, 32'h0}
  };
  logic sys_clk, rst_n, host_req, host_we, host_alias, host_ack, hsr_wr, eng_req, eng_we;
  logic eng_ack, thread_end, channel_select_register_sel_wr, xfer_wr, match_wr, svc_en_wr, svc_en_val;
  logic flag_clr, sub_call, thread_start, thread_running, ok, ok2;
  logic [3:0]           host_addr, eng_addr;
  logic [31:0]          host_wdata, host_rdata, r32;
  logic [1:0]           hsr_channel_select_register, channel_select_register_sel_val, channel_select_register_select_register;
  logic [2:0]           hsr_code;
  logic [NCH-1:0][1:0]  channel_select_register_prio;
  logic [23:0]          eng_wdata, eng_rdata, xfer_wdata_a, xfer_wdata_b, r24;
  logic [23:0]          capture_transfer_regs_a, capture_transfer_regs_b;
  logic [13:0]          sub_ret_addr, ret_addr;
  logic [NCH-1:0]       channel_select_register_event, link_req;
  logic [NCH-1:0][23:0] cap_a, cap_b, match_a, match_b;
  tets_pkg::tets_entry_t thread_entry;
  int                   num_errors, n_compared;
  tets_thread_svc #(.NCH(NCH), .MEM_WORDS(16), .PCW(14)) i_tets_thread_svc (.*);
  tets_host_model #(.AW(4)) i_tets_host_model (.*);
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask : step
  task automatic check1(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : check1
  task automatic check32(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : check32
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic eng_acc(input logic we, input logic [3:0] a, input logic [23:0] d,
                         output logic [23:0] rd, output logic okay);
    step();
    okay = 1'h0;
    {eng_req, eng_we, eng_addr, eng_wdata} = {1'h1, we, a, d};
    for (int i = 0; i < 20 && !okay; i++) begin
      @(posedge sys_clk);
      okay = (eng_ack === 1'h1);
      rd = eng_rdata;
    end
    #1;
    {eng_req, eng_addr, eng_wdata} = {1'h0, ~a, ~d};
  endtask : eng_acc
  task automatic quiet(input int n);
    logic any;
    any = 1'h0;
    repeat (n) begin
      step();
      any = any | (thread_running !== 1'h0);
    end
    check1("no_thread", 1'h0, any);
  endtask : quiet
  task automatic host_service_request(input logic [1:0] ch);
    {hsr_channel_select_register, hsr_code, hsr_wr} = {ch, 3'h1, 1'h1};
    step();
    hsr_wr = 1'h0;
  endtask : host_service_request
  task automatic end_thread();
    thread_end = 1'h1;
    step();
    thread_end = 1'h0;
  endtask : end_thread
  task automatic wait_start(input tets_pkg::tets_entry_t ent, input logic [1:0] ch);
    logic seen;
    seen = 1'h0;
    for (int i = 0; i < 20 && !seen; i++) begin
      step();
      seen = (thread_start === 1'h1);
    end
    check1("thread_start", 1'h1, seen);
    check32("entry", {30'h0, ent}, {30'h0, thread_entry});
    check32("channel_select_register", {30'h0, ch}, {30'h0, channel_select_register_select_register});
    check32("xfer_a", {8'h0, cap_a[ch]}, {8'h0, capture_transfer_regs_a});
    if (!seen) close_out();
  endtask : wait_start
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'h0;
    {hsr_wr, eng_req, eng_we, thread_end, channel_select_register_sel_wr, xfer_wr, match_wr} = '0;
    {svc_en_wr, svc_en_val, flag_clr, sub_call, eng_addr, eng_wdata} = '0;
    {hsr_channel_select_register, hsr_code, channel_select_register_sel_val, xfer_wdata_a, xfer_wdata_b} = '0;
    {sub_ret_addr, channel_select_register_event, link_req} = '0;
    channel_select_register_prio = {2'h1, 2'h2, 2'h3, 2'h0};
    for (int i = 0; i < NCH; i++) begin
      cap_a[i] = 24'h10_0000 + 24'(i);
      cap_b[i] = 24'h20_0000 + 24'(i);
    end
    num_errors = 0;
    n_compared = 0;
    repeat (8) step();
    check1("run_in_reset", 1'h0, thread_running);
    check1("ack_in_reset", 1'h0, host_ack);
    check32("entry_in_reset", 32'h0, {30'h0, thread_entry});
    repeat (8) step();
    rst_n = 1'h1;
    repeat (3) step();
    foreach (ROWS[i]) begin
      if (ROWS[i].eng) begin
        eng_acc(ROWS[i].we, ROWS[i].addr, ROWS[i].wd[23:0], r24, ok);
        r32 = {8'h00, r24};
      end else begin
        i_tets_host_model.access(ROWS[i].we, ROWS[i].als, ROWS[i].addr, ROWS[i].wd, r32, ok);
      end
      check1("ack", 1'h1, ok);
      if (!ROWS[i].we) check32("rdata", ROWS[i].exp, r32);
      if (!ok) close_out();
    end
    // The engine writes a word whose upper byte is known, so the kept bits are never unknown.
    fork
      i_tets_host_model.access(1'h1, 1'h0, 4'h5, 32'h1111_2222, r32, ok);
      eng_acc(1'h1, 4'h1, 24'h33_4444, r24, ok2);
    join
    check1("both_ack", 1'h1, ok & ok2);
    fork
      i_tets_host_model.access(1'h0, 1'h0, 4'h5, 32'h0, r32, ok);
      eng_acc(1'h0, 4'h1, 24'h0, r24, ok2);
    join
    check1("both_ack2", 1'h1, ok & ok2);
    check32("host_word", 32'h1111_2222, r32);
    check32("eng_word", 32'h0033_4444, {8'h0, r24});
    i_tets_host_model.access(1'h0, 1'h0, 4'h1, 32'h0, r32, ok);
    check32("kept_upper", 32'h1233_4444, r32);
    // The bench plays engine code and has a handler for every entry it meets.
    link_req[3] = 1'h1;
    step();
    link_req = '0;
    quiet(10);
    host_service_request(2'h3);
    wait_start(tets_pkg::entry_host, 2'h3);
    end_thread();
    wait_start(tets_pkg::entry_link, 2'h3);
    flag_clr = 1'h1;
    step();
    flag_clr = 1'h0;
    end_thread();
    quiet(10);
    host_service_request(2'h0);
    quiet(10);
    channel_select_register_event[1] = 1'h1;
    step();
    channel_select_register_event = '0;
    quiet(6);
    host_service_request(2'h1);
    wait_start(tets_pkg::entry_host, 2'h1);
    {svc_en_wr, svc_en_val} = 2'h3;
    step();
    svc_en_wr = 1'h0;
    end_thread();
    channel_select_register_event[1] = 1'h1;
    step();
    channel_select_register_event = '0;
    wait_start(tets_pkg::entry_channel_select_register, 2'h1);
    flag_clr = 1'h1;
    step();
    {flag_clr, channel_select_register_sel_wr, channel_select_register_sel_val} = {1'h0, 1'h1, 2'h2};
    step();
    channel_select_register_sel_wr = 1'h0;
    check32("sel", 32'h2, {30'h0, channel_select_register_select_register});
    check32("xfer_b", {8'h0, cap_b[2]}, {8'h0, capture_transfer_regs_b});
    {xfer_wr, xfer_wdata_a, xfer_wdata_b} = {1'h1, 24'h5a_a5a5, 24'ha5_5a5a};
    step();
    {xfer_wr, match_wr} = 2'h1;
    step();
    match_wr = 1'h0;
    check32("match_a", 32'h005a_a5a5, {8'h0, match_a[2]});
    check32("match_b", 32'h00a5_5a5a, {8'h0, match_b[2]});
    {sub_call, sub_ret_addr} = {1'h1, 14'h0123};
    step();
    check32("ret1", 32'h0123, {18'h0, ret_addr});
    sub_ret_addr = 14'h3210;
    step();
    sub_call = 1'h0;
    check32("ret2", 32'h3210, {18'h0, ret_addr});
    end_thread();
    quiet(6);
    rst_n = 1'h0;
    step();
    check1("run_after_rst", 1'h0, thread_running);
    check32("xfer_after_rst", 32'h0, {8'h0, capture_transfer_regs_a});
    rst_n = 1'h1;
    repeat (3) step();
    link_req[3] = 1'h1;
    step();
    link_req = '0;
    quiet(6);
    close_out();
  end
endmodule : tets_thread_svc_test
